// *** rtl/acst_regs.sv ***
// host-visible status and control register bank of the accelerometer
module acst_regs #(
  parameter logic [7:0] IDENT = acst_pkg::IDENT_DEFAULT, // arbitrary value
  parameter int PULSE_CYCLES = acst_pkg::PULSE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire acst_pkg::acst_req_t REG_REQ,
  input wire acst_pkg::acst_evt_t EVT,
  input wire logic IRQ_PULSE_MODE,
  input wire logic MOTION_UNLATCHED,
  input wire logic SELFTEST_SET,
  output logic [7:0] REG_RDATA,
  output logic [7:0] MAIN_CTRL,
  output logic SELFTEST_START,
  output logic IRQ_OUT
);
  import acst_pkg::*;

  localparam acst_state_t STATE_RESET = '{
    ctrl: CTRL_RESET,
    cur: ORIENT_RESET,
    prev: ORIENT_RESET,
    default: '0
  };

  acst_state_t s_reg;
  acst_state_t s_next;

  //////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // event source byte, motion bit live or latched per the selected response
  function automatic logic [7:0] event_byte(acst_state_t st, logic unl);
    logic mot;
    mot = unl ? st.motion_live : st.motion_latched;
    event_byte = {3'h0, st.new_sample, st.knock_type, mot,
                  st.orient_chg};
  endfunction : event_byte

  // interrupt level in latched mode, unlatched motion added on top
  function automatic logic int_level(acst_state_t st, logic unl);
    int_level = st.int_status |
                (unl & st.motion_live & st.ctrl[CTRL_MOTION_EN]);
  endfunction : int_level

  // read multiplexer, unmapped offsets answer zero
  function automatic logic [7:0] read_value(logic [7:0] a,
                                            acst_state_t st, logic unl);
    case (a)
      ADDR_Z_HIGH: read_value = st.z_hi;
      ADDR_SELFTEST: read_value = st.comm_selftest_start ? SELFTEST_ACTIVE
                                          : SELFTEST_IDLE;
      ADDR_IDENT: read_value = IDENT;
      ADDR_ORIENT_CUR: read_value = {2'h0, st.cur};
      ADDR_ORIENT_PREV: read_value = {2'h0, st.prev};
      ADDR_KNOCK_SRC: read_value = {2'h0, st.knock_dir};
      ADDR_EVENT_SRC: read_value = event_byte(st, unl);
      ADDR_STATUS: read_value = 8'(int_level(st, unl)) << STATUS_INT;
      ADDR_MAIN_CTRL: read_value = st.ctrl;
      default: read_value = UNMAPPED_VALUE;
    endcase
  endfunction : read_value

  //////////////////////////////////////////////////////////////////////////
  // next-state logic

  logic rd_release;
  logic rd_accel;
  logic rd_selftest;
  logic wr_ctrl;
  logic ev_knock;
  logic ev_motion;
  logic ev_orient;
  logic ev_sample;
  logic new_event;

  // access decode; accel data spans the low byte of X up to z high
  assign rd_release = REG_REQ.rd && (REG_REQ.addr == ADDR_IRQ_RELEASE);
  assign rd_accel = REG_REQ.rd && (REG_REQ.addr >= ADDR_ACCEL_FIRST) &&
                    (REG_REQ.addr <= ADDR_Z_HIGH);
  assign rd_selftest = REG_REQ.rd && (REG_REQ.addr == ADDR_SELFTEST);
  assign wr_ctrl = REG_REQ.wr && (REG_REQ.addr == ADDR_MAIN_CTRL);

  // an orientation change is only applied once no read is under way
  assign ev_orient = s_reg.pend_valid && !REG_REQ.reading &&
                     (s_reg.pend != s_reg.cur) &&
                     s_reg.ctrl[CTRL_ORIENT_EN];
  assign ev_knock = EVT.knock_stb && s_reg.ctrl[CTRL_KNOCK_EN];
  assign ev_motion = EVT.motion_stb && s_reg.ctrl[CTRL_MOTION_EN];
  assign ev_sample = EVT.sample_stb && s_reg.ctrl[CTRL_NEW_IRQ_EN];
  // unlatched motion drives the pin as a level in latched mode only, not through the latch
  assign new_event = ev_knock || ev_orient || ev_sample ||
                     (ev_motion && !MOTION_UNLATCHED);

  // one combinational pass over the whole state; clears come first so
  // that an event in the same cycle as its clear still sets the flag
  always_comb begin
    s_next = s_reg;
    if (REG_REQ.rd) begin
      s_next.rdata = read_value(REG_REQ.addr, s_reg, MOTION_UNLATCHED);
    end
    // control register; while running only the run bit moves
    if (wr_ctrl) begin
      if (s_reg.ctrl[CTRL_RUN]) begin
        s_next.ctrl[CTRL_RUN] = REG_REQ.wdata[CTRL_RUN];
      end else begin
        s_next.ctrl = REG_REQ.wdata;
      end
    end
    // self-test start bit: read clears, set from the other control wins
    if (rd_selftest) begin
      s_next.comm_selftest_start = 1'b0;
    end
    if (SELFTEST_SET) begin
      s_next.comm_selftest_start = 1'b1;
    end
    // z sample capture
    if (EVT.sample_stb) begin
      s_next.z_hi = EVT.z_sample[11:4];
    end
    // orientation: park new states, apply outside host reads
    if (s_reg.pend_valid && !REG_REQ.reading) begin
      s_next.pend_valid = 1'b0;
      if (s_reg.pend != s_reg.cur) begin
        s_next.prev = s_reg.cur;
        s_next.cur = s_reg.pend;
      end
    end
    if (EVT.orient_stb) begin
      s_next.pend_valid = 1'b1;
      s_next.pend = EVT.orient_state;
    end
    // release read clears every latched source and the status
    if (rd_release) begin
      s_next.knock_dir = 6'h00;
      s_next.knock_type = KNOCK_NONE;
      s_next.motion_latched = 1'b0;
      s_next.orient_chg = 1'b0;
      s_next.int_status = 1'b0;
      s_next.pulse_cnt = 16'h0000;
    end
    if (rd_release || rd_accel) begin
      s_next.new_sample = 1'b0;
    end
    // event sets
    if (EVT.sample_stb) begin
      s_next.new_sample = 1'b1;
    end
    if (ev_knock) begin
      s_next.knock_dir = EVT.knock_dir;
      s_next.knock_type = EVT.knock_double ? KNOCK_DOUBLE
                                           : KNOCK_SINGLE;
    end
    if (ev_motion) begin
      s_next.motion_latched = 1'b1;
    end
    if (ev_orient) begin
      s_next.orient_chg = 1'b1;
    end
    s_next.motion_live = EVT.motion_level;
    if (new_event) begin
      s_next.int_status = 1'b1;
    end
    // interrupt output: count down a fixed pulse or follow the latch
    if (new_event) begin
      s_next.pulse_cnt = 16'(PULSE_CYCLES);
    end else if (s_reg.pulse_cnt != 16'h0000 && !rd_release) begin
      s_next.pulse_cnt = s_reg.pulse_cnt - 16'h0001;
    end
    if (IRQ_PULSE_MODE) begin
      s_next.irq = (s_next.pulse_cnt != 16'h0000);
    end else begin
      s_next.irq = int_level(s_next, MOTION_UNLATCHED);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset to the documented values
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state flops
  assign REG_RDATA = s_reg.rdata;
  assign MAIN_CTRL = s_reg.ctrl;
  assign SELFTEST_START = s_reg.comm_selftest_start;
  assign IRQ_OUT = s_reg.irq;

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  sequence seq_release_quiet;
    rd_release && !new_event && !EVT.sample_stb && !ev_motion;
  endsequence

  sequence seq_all_clear;
    event_byte(s_reg, 1'b0) == 8'h00 && s_reg.knock_dir == 6'h00 &&
    !s_reg.int_status;
  endsequence

  a_z_high_read: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_Z_HIGH && !EVT.sample_stb
    |=> REG_RDATA == $past(s_reg.z_hi))
    else $error("z high read returned wrong byte");

  a_selftest_reply: assert property (
    rd_selftest && s_reg.comm_selftest_start |=> REG_RDATA == SELFTEST_ACTIVE)
    else $error("self-test reply not 0xAA while started");

  a_selftest_clear: assert property (
    rd_selftest && !SELFTEST_SET |=> !SELFTEST_START)
    else $error("self-test start did not clear on read");

  a_selftest_idle: assert property (
    rd_selftest && !s_reg.comm_selftest_start |=> REG_RDATA == SELFTEST_IDLE)
    else $error("self-test reply not 0x55 while idle");

  a_orient_hold: assert property (
    REG_REQ.reading [*2] |-> $stable(s_reg.cur) && $stable(s_reg.prev))
    else $error("orientation changed during host read");

  a_orient_upper: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_ORIENT_CUR
    |=> REG_RDATA[7:6] == 2'h0)
    else $error("orientation upper bits not zero");

  a_release_clear: assert property (
    seq_release_quiet |=> seq_all_clear)
    else $error("release read left sources set");

  a_release_pin: assert property (
    (seq_release_quiet and (!IRQ_PULSE_MODE && !MOTION_UNLATCHED))
    |=> !IRQ_OUT)
    else $error("interrupt output not cleared by release");

  sequence seq_sample_clear;
    (rd_accel || rd_release) && !EVT.sample_stb;
  endsequence

  a_sample_flag: assert property (
    EVT.sample_stb |=> s_reg.new_sample)
    else $error("new-sample flag did not set");

  a_sample_clear: assert property (
    seq_sample_clear |=> !s_reg.new_sample)
    else $error("new-sample flag did not clear on read");

  a_knock_type: assert property (
    s_reg.knock_type != 2'h3)
    else $error("knock type code 11 produced");

  a_ctrl_guard: assert property (
    wr_ctrl && MAIN_CTRL[CTRL_RUN] |=> $stable(MAIN_CTRL[6:0]))
    else $error("control field changed while running");

  a_irq_enable: assert property (
    ev_sample && !IRQ_PULSE_MODE |=> IRQ_OUT && s_reg.int_status)
    else $error("enabled new sample did not raise interrupt");

  a_pulse_width: assert property (
    IRQ_PULSE_MODE && $fell(IRQ_OUT) && !$past(rd_release)
    |-> $past(s_reg.pulse_cnt) == 16'h0001)
    else $error("interrupt pulse ended at wrong count");

  // register contents as the host sees them
  a_ident_read: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_IDENT |=> REG_RDATA == IDENT)
    else $error("identity read returned wrong byte");

  a_prev_upper: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_ORIENT_PREV
    |=> REG_RDATA[7:6] == 2'h0)
    else $error("previous orientation upper bits not zero");

  a_knock_upper: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_KNOCK_SRC
    |=> REG_RDATA[7:6] == 2'h0)
    else $error("knock direction upper bits not zero");

  a_event_upper: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_EVENT_SRC
    |=> REG_RDATA[7:5] == 3'h0)
    else $error("event source upper bits not zero");

  // reset values; these must hold while reset is still low
  a_ctrl_reset: assert property (
    disable iff (1'b0)
    !NRST |=> MAIN_CTRL == CTRL_RESET && !IRQ_OUT)
    else $error("control or interrupt not cleared by reset");

  a_orient_reset: assert property (
    disable iff (1'b0)
    !NRST |=> s_reg.cur == ORIENT_RESET && s_reg.prev == ORIENT_RESET)
    else $error("orientation registers not at reset value");

  a_ctrl_write: assert property (
    wr_ctrl && !MAIN_CTRL[CTRL_RUN] |=> MAIN_CTRL == $past(REG_REQ.wdata))
    else $error("standby write to control did not land");

  // latched sources move only on their event or on release
  sequence seq_knock_quiet;
    !ev_knock && !rd_release;
  endsequence

  a_knock_capture: assert property (
    ev_knock |=> s_reg.knock_dir == $past(EVT.knock_dir))
    else $error("knock direction not captured");

  a_knock_hold: assert property (
    seq_knock_quiet |=> $stable(s_reg.knock_dir))
    else $error("knock direction moved without event or release");

  a_motion_latch: assert property (
    ev_motion |=> s_reg.motion_latched)
    else $error("motion event not latched");

  a_motion_live: assert property (
    MOTION_UNLATCHED && REG_REQ.rd && REG_REQ.addr == ADDR_EVENT_SRC
    |=> REG_RDATA[EVT_MOTION] == $past(s_reg.motion_live))
    else $error("unlatched motion flag not live");

  a_orient_change: assert property (
    ev_orient |=> s_reg.orient_chg && s_reg.cur == $past(s_reg.pend) &&
    s_reg.prev == $past(s_reg.cur))
    else $error("orientation change not applied");

  a_orient_same: assert property (
    s_reg.pend_valid && s_reg.pend == s_reg.cur && !rd_release
    |=> $stable(s_reg.orient_chg))
    else $error("orientation flag moved without a change");

  a_orient_disabled: assert property (
    !s_reg.ctrl[CTRL_ORIENT_EN] && !s_reg.orient_chg
    |=> !s_reg.orient_chg)
    else $error("disabled orientation detection set its flag");

  // status and interrupt output
  a_status_bit: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_STATUS && s_reg.int_status
    |=> REG_RDATA == (8'h01 << STATUS_INT))
    else $error("status read missed the interrupt bit");

  a_pulse_start: assert property (
    IRQ_PULSE_MODE && new_event |=> IRQ_OUT)
    else $error("event did not start an interrupt pulse");

  a_latched_hold: assert property (
    !IRQ_PULSE_MODE && s_reg.int_status && !rd_release
    |=> IRQ_OUT && s_reg.int_status)
    else $error("latched interrupt dropped before release");

  a_no_sample_irq: assert property (
    EVT.sample_stb && !new_event && !s_reg.int_status
    |=> !s_reg.int_status)
    else $error("disabled new sample raised the interrupt");

endmodule : acst_regs

// *** rtl/acst_pkg.sv ***
// constants and carrier types for the accelerometer status and control bank
package acst_pkg;
  // register offsets
  localparam logic [7:0] ADDR_ACCEL_FIRST = 8'h06;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h0B;
  localparam logic [7:0] ADDR_SELFTEST = 8'h0C;
  localparam logic [7:0] ADDR_IDENT = 8'h0F;
  localparam logic [7:0] ADDR_ORIENT_CUR = 8'h10;
  localparam logic [7:0] ADDR_ORIENT_PREV = 8'h11;
  localparam logic [7:0] ADDR_KNOCK_SRC = 8'h15;
  localparam logic [7:0] ADDR_EVENT_SRC = 8'h16;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_RELEASE = 8'h1A;
  localparam logic [7:0] ADDR_MAIN_CTRL = 8'h1B;
  // reset and fixed values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] ORIENT_RESET = 6'h20;
  localparam logic [7:0] SELFTEST_IDLE = 8'h55;
  localparam logic [7:0] SELFTEST_ACTIVE = 8'hAA;
  localparam logic [7:0] IDENT_DEFAULT = 8'h5A; // arbitrary value
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  // main control field positions
  localparam int CTRL_RUN = 7;
  localparam int CTRL_PRECISION = 6;
  localparam int CTRL_NEW_IRQ_EN = 5;
  localparam int CTRL_RANGE_HI = 4;
  localparam int CTRL_RANGE_LO = 3;
  localparam int CTRL_KNOCK_EN = 2;
  localparam int CTRL_MOTION_EN = 1;
  localparam int CTRL_ORIENT_EN = 0;
  // event source and status field positions
  localparam int EVT_NEW_SAMPLE = 4;
  localparam int EVT_MOTION = 1;
  localparam int EVT_ORIENT = 0;
  localparam int STATUS_INT = 4;
  // knock type codes
  localparam logic [1:0] KNOCK_NONE = 2'h0;
  localparam logic [1:0] KNOCK_SINGLE = 2'h1;
  localparam logic [1:0] KNOCK_DOUBLE = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_TIME_NS = 50000;
  localparam int PULSE_CYCLES = PULSE_TIME_NS / CLK_PERIOD_NS;

  // register access from the serial front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic reading;
  } acst_req_t;

  // events from the sensing and detection logic
  typedef struct packed {
    logic [11:0] z_sample;
    logic sample_stb;
    logic orient_stb;
    logic [5:0] orient_state;
    logic knock_stb;
    logic [5:0] knock_dir;
    logic knock_double;
    logic motion_stb;
    logic motion_level;
  } acst_evt_t;

  // whole state of the bank
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] z_hi;
    logic [5:0] cur;
    logic [5:0] prev;
    logic pend_valid;
    logic [5:0] pend;
    logic [5:0] knock_dir;
    logic [1:0] knock_type;
    logic motion_latched;
    logic motion_live;
    logic orient_chg;
    logic new_sample;
    logic int_status;
    logic comm_selftest_start;
    logic [15:0] pulse_cnt;
    logic irq;
    logic [7:0] rdata;
  } acst_state_t;
endpackage : acst_pkg

// *** dv/acst_host.sv ***
// host model that reaches the register bank through the strobe port
module acst_host (
  input wire logic clk,
  output acst_pkg::acst_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  import acst_pkg::*;
  initial req = '0;
  ////////////////////////////////////////////////////////////////////////////
  // one strobe per access; reading stays up one cycle past the strobe
  task automatic access(input logic [7:0] a, input logic [7:0] d,
                        input logic w);
    @(negedge clk);
    req.addr = a;
    req.wdata = d;
    req.wr = w;
    req.rd = !w;
    req.reading = !w;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    @(negedge clk);
    req.reading = 1'b0;
  endtask : access
  // standby first, then the new bits, run bit last
  task automatic set_ctrl(input logic [7:0] v);
    access(ADDR_MAIN_CTRL, 8'h00, 1'b1);
    access(ADDR_MAIN_CTRL, {1'b0, v[6:0]}, 1'b1);
    access(ADDR_MAIN_CTRL, v, 1'b1);
  endtask : set_ctrl
endmodule : acst_host

// *** dv/acst_regs_test.sv ***
// self-checking bench for the status and control register bank
module acst_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import acst_pkg::*;
  localparam logic [7:0] ID = 8'h3C; // arbitrary value
  localparam int PW = 20; // short pulse keeps the run brief
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  acst_req_t req;
  acst_evt_t ev = '0;
  logic pmode = 1'b0;
  logic st_set = 1'b0;
  logic unl = 1'b0;
  logic [7:0] rdata;
  logic [7:0] ctrl;
  logic st_start;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  acst_host host_u (.clk(SYS_CLK), .req(req));
  acst_regs #(.IDENT(ID), .PULSE_CYCLES(PW)) dut_u (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .REG_REQ(req), .EVT(ev),
    .IRQ_PULSE_MODE(pmode), .MOTION_UNLATCHED(unl),
    .SELFTEST_SET(st_set), .REG_RDATA(rdata), .MAIN_CTRL(ctrl),
    .SELFTEST_START(st_start), .IRQ_OUT(irq));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_u.access(a, 8'h00, 1'b0);
    chk(rdata, e);
  endtask : rd
  // release read; its own data is not judged
  task automatic rel();
    host_u.access(ADDR_IRQ_RELEASE, 8'h00, 1'b0);
  endtask : rel
  // strobes last exactly one cycle
  task automatic pulse(input acst_evt_t e);
    @(negedge SYS_CLK);
    ev = e;
    @(negedge SYS_CLK);
    ev = '0;
  endtask : pulse
  task automatic knock(input logic [5:0] d, input logic dbl);
    acst_evt_t e;
    e = '0;
    e.knock_stb = 1'b1;
    e.knock_dir = d;
    e.knock_double = dbl;
    pulse(e);
  endtask : knock
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_MAIN_CTRL, 8'h00);
    rd(ADDR_ORIENT_CUR, 8'h20);
    rd(ADDR_ORIENT_PREV, 8'h20);
    rd(ADDR_SELFTEST, 8'h55);
    rd(ADDR_IDENT, ID);
    rd(8'h30, UNMAPPED_VALUE);
  endtask : s_reset
  // writes while running may only move the run bit
  task automatic s_ctrl();
    host_u.set_ctrl(8'h9F);
    chk(ctrl, 8'h9F);
    host_u.access(ADDR_MAIN_CTRL, 8'h80, 1'b1);
    chk(ctrl, 8'h9F);
    host_u.access(ADDR_MAIN_CTRL, 8'h00, 1'b1);
    chk(ctrl, 8'h1F);
  endtask : s_ctrl
  task automatic s_selftest();
    @(negedge SYS_CLK);
    st_set = 1'b1;
    @(negedge SYS_CLK);
    st_set = 1'b0;
    chk({7'h0, st_start}, 8'h01);
    rd(ADDR_SELFTEST, 8'hAA);
    chk({7'h0, st_start}, 8'h00);
    rd(ADDR_SELFTEST, 8'h55);
  endtask : s_selftest
  task automatic s_knock();
    host_u.set_ctrl(8'h84);
    knock(6'h10, 1'b1);
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_KNOCK_SRC, 8'h10);
    rd(ADDR_EVENT_SRC, 8'h08);
    rd(ADDR_STATUS, 8'h10);
    rel();
    chk({7'h0, irq}, 8'h00);
    rd(ADDR_EVENT_SRC, 8'h00);
    rd(ADDR_KNOCK_SRC, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    knock(6'h01, 1'b0);
    rd(ADDR_EVENT_SRC, 8'h04);
    rel();
    host_u.set_ctrl(8'h80);
    knock(6'h02, 1'b0);
    rd(ADDR_EVENT_SRC, 8'h00);
  endtask : s_knock
  task automatic s_sample(input logic [7:0] c, input logic i);
    acst_evt_t e;
    host_u.set_ctrl(c);
    e = '0;
    e.sample_stb = 1'b1;
    e.z_sample = 12'hABC;
    pulse(e);
    chk({7'h0, irq}, {7'h0, i});
    rd(ADDR_EVENT_SRC, 8'h10);
    rd(ADDR_Z_HIGH, 8'hAB);
    rd(ADDR_EVENT_SRC, 8'h00);
    rel();
  endtask : s_sample
  task automatic s_orient();
    acst_evt_t e;
    host_u.set_ctrl(8'h81);
    e = '0;
    e.orient_stb = 1'b1;
    e.orient_state = 6'h01;
    pulse(e);
    repeat (2) @(negedge SYS_CLK);
    rd(ADDR_ORIENT_CUR, 8'h01);
    rd(ADDR_ORIENT_PREV, 8'h20);
    rd(ADDR_EVENT_SRC, 8'h01);
    rel();
    pulse(e);
    repeat (2) @(negedge SYS_CLK);
    rd(ADDR_EVENT_SRC, 8'h00);
    // a new state arriving during a read is parked until the read ends
    e.orient_state = 6'h10;
    fork
      rd(ADDR_ORIENT_CUR, 8'h01);
      pulse(e);
    join
    rd(ADDR_ORIENT_CUR, 8'h10);
    rd(ADDR_ORIENT_PREV, 8'h01);
    rel();
  endtask : s_orient
  // motion flag latched first, then live while unlatched is selected
  task automatic s_motion();
    acst_evt_t e;
    host_u.set_ctrl(8'h82);
    e = '0;
    e.motion_stb = 1'b1;
    e.motion_level = 1'b1;
    pulse(e);
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_EVENT_SRC, 8'h02);
    rel();
    rd(ADDR_EVENT_SRC, 8'h00);
    @(negedge SYS_CLK);
    unl = 1'b1;
    ev.motion_level = 1'b1;
    rd(ADDR_EVENT_SRC, 8'h02);
    chk({7'h0, irq}, 8'h01);
    rd(ADDR_STATUS, 8'h10);
    @(negedge SYS_CLK);
    ev.motion_level = 1'b0;
    rd(ADDR_EVENT_SRC, 8'h00);
    chk({7'h0, irq}, 8'h00);
    unl = 1'b0;
  endtask : s_motion
  // pulse mode: the pin stays up for exactly the pulse length
  task automatic s_pulse();
    int n;
    pmode = 1'b1;
    host_u.set_ctrl(8'h84);
    knock(6'h20, 1'b0);
    n = 0;
    while (irq === 1'b1 && n < 100) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (n >= 100) begin
      fail_count++;
      report_and_stop();
    end
    chk(n[7:0], PW[7:0]);
    rel();
  endtask : s_pulse
  task automatic report_and_stop();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge SYS_CLK);
    NRST = 1'b1;
    s_reset();
    s_ctrl();
    s_selftest();
    s_knock();
    s_sample(8'hA0, 1'b1);
    s_sample(8'h80, 1'b0);
    s_orient();
    s_motion();
    s_pulse();
    report_and_stop();
  end
endmodule : acst_regs_test
